// File: logic/fepc_ctrl.sv
// Purpose: host-side sequencer that programs ECC-protected words into the flash
// Assumes: device answers each request with a one-cycle ack; rdata valid with ack
// Notes: one request in flight; erase and command unlock cycles are out of scope
// Functional notes
// - after each half-word write read flags once, discard, then poll until done
// - program only whole aligned words as two half writes, lower half first
// - afterwards return to word read, dummy read, verify; correction flag means reprogram
// - no reset may strike while program or erase runs
// - in programming mode no flash fetches and no flash-vectored interrupts
// - in programming mode no sub-clock or low-power mode
// - in word read mode never write the flash array
// - in programming mode write flash only as half words
// - after any algorithm command one dummy read precedes wanted reads
// - before low power confirm the programming algorithm has finished
// - access size changed from outside flash, followed by a dummy register read
// - hang flag set after timing limit; host then issues reset command
//
// The placing of the registers and the strobed register port are this design's own decisions.
`timescale 1ns/1ns
module fepc_ctrl #(
    parameter int POLL_LIMIT = 4096
) (
    input wire logic sys_clk_i,
    input wire logic sys_rst_i,
    input wire logic [7:0] sw_addr_i,
    input wire logic [31:0] sw_wdata_i,
    input wire logic sw_wr_i,
    input wire logic sw_rd_i,
    output logic [31:0] sw_rdata_o,
    output fepc_pkg::fepc_dev_req_type dev_req_o,
    input wire fepc_pkg::fepc_dev_rsp_type dev_rsp_i,
    output logic prog_mode_o,
    output logic busy_o
);
    typedef enum logic [4:0] {
        ST_IDLE, ST_ASZ_P_WR, ST_ASZ_P_RD, ST_LO_WR, ST_LO_DUMMY, ST_LO_POLL, ST_LO_STS,
        ST_HI_WR, ST_HI_DUMMY, ST_HI_POLL, ST_HI_STS, ST_HANG_CMD, ST_ASZ_R_WR,
        ST_ASZ_R_RD, ST_RD_DUMMY, ST_VERIFY, ST_EER_RD, ST_TRIM_RD, ST_SLOW_WR,
        ST_SLOW_RD, ST_EER_CLR
    } fepc_state_type;

    fepc_state_type state_r, state_nxt;
    fepc_pkg::fepc_dev_req_type req_r, req_nxt;
    logic pend_r, pend_nxt;
    logic [31:0] word_addr_r, word_addr_nxt;
    logic [31:0] write_word_r, write_word_nxt;
    logic [1:0] mode_r, mode_nxt;
    logic [2:0] extra_wait_sel_r, extra_wait_sel_nxt;
    logic [fepc_pkg::TRIM_W-1:0] trim_value_r, trim_value_nxt;
    logic [5:0] stat_r, stat_nxt;
    logic [15:0] poll_cnt_r, poll_cnt_nxt;
    logic lo_ok_r, lo_ok_nxt;
    logic [31:0] sw_rdata_r, sw_rdata_nxt;
    logic ack;
    logic [31:0] rd;

    assign ack = pend_r && dev_rsp_i.ack;
    assign rd = dev_rsp_i.rdata;

    // legal slow-down codes are zero and the odd ones
    function automatic logic slow_legal(input logic [2:0] code);
        slow_legal = (code == 3'h0) || code[0];
    endfunction

    // access issued in each state
    always_comb begin
        req_nxt = req_r;
        req_nxt.req = 1'b0;
        req_nxt.we = 1'b0;
        req_nxt.size = fepc_pkg::SIZE_WORD;
        req_nxt.wdata = 32'h0000_0000;
        unique case (state_nxt)
            ST_ASZ_P_WR: begin
                req_nxt.we = 1'b1;
                req_nxt.addr = fepc_pkg::DEV_ACCESS_SIZE;
                req_nxt.wdata = {30'h0000_0000, fepc_pkg::ASZ_PROG};
            end
            ST_ASZ_R_WR: begin
                req_nxt.we = 1'b1;
                req_nxt.addr = fepc_pkg::DEV_ACCESS_SIZE;
                req_nxt.wdata = {30'h0000_0000, fepc_pkg::ASZ_ROM};
            end
            ST_ASZ_P_RD, ST_ASZ_R_RD: req_nxt.addr = fepc_pkg::DEV_ACCESS_SIZE;
            ST_LO_WR: begin
                req_nxt.we = 1'b1;
                req_nxt.size = fepc_pkg::SIZE_HALF;
                req_nxt.addr = word_addr_r;
                req_nxt.wdata = {16'h0000, write_word_r[15:0]};
            end
            ST_HI_WR: begin
                req_nxt.we = 1'b1;
                req_nxt.size = fepc_pkg::SIZE_HALF;
                req_nxt.addr = word_addr_r + fepc_pkg::WORD_HI_OFS;
                req_nxt.wdata = {16'h0000, write_word_r[31:16]};
            end
            ST_LO_DUMMY, ST_LO_POLL, ST_HI_DUMMY, ST_HI_POLL: begin
                req_nxt.size = fepc_pkg::SIZE_HALF;
                req_nxt.addr = word_addr_r;
            end
            ST_RD_DUMMY, ST_VERIFY: req_nxt.addr = word_addr_r;
            ST_LO_STS, ST_HI_STS, ST_EER_RD: req_nxt.addr = fepc_pkg::DEV_STATUS;
            ST_HANG_CMD: begin
                // reset command goes out half-word sized while the array is in programming mode
                req_nxt.we = 1'b1;
                req_nxt.size = (mode_r == fepc_pkg::ASZ_PROG) ? fepc_pkg::SIZE_HALF : fepc_pkg::SIZE_WORD;
                req_nxt.addr = word_addr_r;
                req_nxt.wdata = fepc_pkg::RESET_CMD;
            end
            ST_TRIM_RD: req_nxt.addr = fepc_pkg::DEV_TRIM_MIRROR;
            ST_SLOW_WR: begin
                req_nxt.we = 1'b1;
                req_nxt.addr = fepc_pkg::DEV_SLOW_DOWN;
                req_nxt.wdata = {29'h0000_0000, extra_wait_sel_r};
            end
            ST_SLOW_RD: req_nxt.addr = fepc_pkg::DEV_SLOW_DOWN;
            ST_EER_CLR: begin
                // zero in the correction bit clears it, ones elsewhere touch nothing writable
                req_nxt.we = 1'b1;
                req_nxt.addr = fepc_pkg::DEV_STATUS;
                req_nxt.wdata = fepc_pkg::EER_CLEAR_WORD;
            end
            ST_IDLE: req_nxt.addr = req_r.addr;
        endcase
        // request stays up until the device acks; a pulse would be lost on a slow device
        if (state_nxt != ST_IDLE) begin
            req_nxt.req = 1'b1;
        end
    end

    // sequencer
    always_comb begin
        state_nxt = state_r;
        pend_nxt = pend_r;
        word_addr_nxt = word_addr_r;
        write_word_nxt = write_word_r;
        mode_nxt = mode_r;
        extra_wait_sel_nxt = extra_wait_sel_r;
        trim_value_nxt = trim_value_r;
        stat_nxt = stat_r;
        poll_cnt_nxt = poll_cnt_r;
        lo_ok_nxt = lo_ok_r;
        if (sw_wr_i && state_r == ST_IDLE) begin
            unique case (sw_addr_i)
                fepc_pkg::REG_ADDR: word_addr_nxt = {sw_wdata_i[31:2], 2'h0};
                fepc_pkg::REG_DATA: write_word_nxt = sw_wdata_i;
                fepc_pkg::REG_SLOW: extra_wait_sel_nxt = sw_wdata_i[2:0];
                fepc_pkg::REG_CTRL: begin
                    if (sw_wdata_i[fepc_pkg::CTRL_PROG]) begin
                        stat_nxt = 6'h01;
                        lo_ok_nxt = 1'b0;
                        state_nxt = ST_ASZ_P_WR;
                    end else if (sw_wdata_i[fepc_pkg::CTRL_TRIM]) begin
                        stat_nxt = 6'h01;
                        state_nxt = ST_TRIM_RD;
                    end else if (sw_wdata_i[fepc_pkg::CTRL_CLR_EER]) begin
                        stat_nxt = 6'h01;
                        state_nxt = ST_EER_CLR;
                    end else if (sw_wdata_i[fepc_pkg::CTRL_SLOW]) begin
                        // prohibited codes never reach the device
                        if (slow_legal(extra_wait_sel_r)) begin
                            stat_nxt = 6'h01;
                            state_nxt = ST_SLOW_WR;
                        end else begin
                            stat_nxt[fepc_pkg::STAT_SLOW_BAD] = 1'b1;
                        end
                    end
                end
                default: ;
            endcase
        end
        if (state_nxt != state_r) begin
            pend_nxt = 1'b1;
        end
        if (ack) begin
            pend_nxt = 1'b1;
            unique case (state_r)
                ST_ASZ_P_WR: begin
                    mode_nxt = fepc_pkg::ASZ_PROG;
                    state_nxt = ST_ASZ_P_RD;
                end
                ST_ASZ_P_RD: state_nxt = ST_LO_WR;
                ST_LO_WR: state_nxt = ST_LO_DUMMY;
                ST_LO_DUMMY: begin
                    poll_cnt_nxt = 16'h0000;
                    state_nxt = ST_LO_POLL;
                end
                ST_LO_POLL, ST_HI_POLL: begin
                    poll_cnt_nxt = poll_cnt_r + 16'h0001;
                    if (rd[fepc_pkg::FLAG_DONE_POLARITY]) begin
                        lo_ok_nxt = (state_r == ST_LO_POLL);
                        state_nxt = (state_r == ST_LO_POLL) ? ST_HI_WR : ST_ASZ_R_WR;
                    end else begin
                        state_nxt = (state_r == ST_LO_POLL) ? ST_LO_STS : ST_HI_STS;
                    end
                end
                ST_LO_STS, ST_HI_STS: begin
                    if (rd[fepc_pkg::DSTAT_HANG] || poll_cnt_r == 16'(POLL_LIMIT)) begin
                        stat_nxt[fepc_pkg::STAT_HANG] = 1'b1;
                        state_nxt = ST_HANG_CMD;
                    end else begin
                        state_nxt = (state_r == ST_LO_STS) ? ST_LO_POLL : ST_HI_POLL;
                    end
                end
                ST_HI_WR: state_nxt = ST_HI_DUMMY;
                ST_HI_DUMMY: begin
                    poll_cnt_nxt = 16'h0000;
                    state_nxt = ST_HI_POLL;
                end
                ST_HANG_CMD: state_nxt = ST_ASZ_R_WR;
                ST_ASZ_R_WR: begin
                    mode_nxt = fepc_pkg::ASZ_ROM;
                    state_nxt = ST_ASZ_R_RD;
                end
                ST_ASZ_R_RD: state_nxt = stat_r[fepc_pkg::STAT_HANG] ? ST_IDLE : ST_RD_DUMMY;
                ST_RD_DUMMY: state_nxt = ST_VERIFY;
                ST_VERIFY: begin
                    stat_nxt[fepc_pkg::STAT_VERIFY] = (rd != write_word_r);
                    state_nxt = ST_EER_RD;
                end
                ST_EER_RD: begin
                    // a corrected read means software must erase and reprogram
                    stat_nxt[fepc_pkg::STAT_ECC] = rd[fepc_pkg::DSTAT_EER];
                    state_nxt = ST_IDLE;
                end
                ST_TRIM_RD: begin
                    trim_value_nxt = rd[fepc_pkg::TRIM_W-1:0];
                    state_nxt = ST_IDLE;
                end
                ST_SLOW_WR: state_nxt = ST_SLOW_RD;
                default: state_nxt = ST_IDLE;
            endcase
            if (state_nxt == ST_IDLE) begin
                pend_nxt = 1'b0;
                stat_nxt[fepc_pkg::STAT_BUSY] = 1'b0;
                stat_nxt[fepc_pkg::STAT_DONE] = 1'b1;
            end
        end
    end

    always_comb begin
        sw_rdata_nxt = 32'h0000_0000;
        unique case (sw_addr_i)
            fepc_pkg::REG_ADDR: sw_rdata_nxt = word_addr_r;
            fepc_pkg::REG_DATA: sw_rdata_nxt = write_word_r;
            fepc_pkg::REG_STAT: sw_rdata_nxt = {26'h000_0000, stat_r};
            fepc_pkg::REG_TRIM: sw_rdata_nxt = {22'h00_0000, trim_value_r};
            fepc_pkg::REG_SLOW: sw_rdata_nxt = {29'h0000_0000, extra_wait_sel_r};
            default: ;
        endcase
        if (!sw_rd_i) begin
            sw_rdata_nxt = 32'h0000_0000;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            state_r <= ST_IDLE;
            req_r <= '0;
            pend_r <= 1'b0;
            word_addr_r <= 32'h0000_0000;
            write_word_r <= 32'h0000_0000;
            mode_r <= fepc_pkg::ASZ_RESET;
            extra_wait_sel_r <= 3'h0;
            trim_value_r <= '0;
            stat_r <= 6'h00;
            poll_cnt_r <= 16'h0000;
            lo_ok_r <= 1'b0;
            sw_rdata_r <= 32'h0000_0000;
        end else begin
            state_r <= state_nxt;
            req_r <= req_nxt;
            pend_r <= pend_nxt;
            word_addr_r <= word_addr_nxt;
            write_word_r <= write_word_nxt;
            mode_r <= mode_nxt;
            extra_wait_sel_r <= extra_wait_sel_nxt;
            trim_value_r <= trim_value_nxt;
            stat_r <= stat_nxt;
            poll_cnt_r <= poll_cnt_nxt;
            lo_ok_r <= lo_ok_nxt;
            sw_rdata_r <= sw_rdata_nxt;
        end
    end

    assign dev_req_o = req_r;
    assign sw_rdata_o = sw_rdata_r;
    // system must hold off sleep, flash fetches and resets while these are high
    assign prog_mode_o = (mode_r == fepc_pkg::ASZ_PROG);
    assign busy_o = (state_r != ST_IDLE);

    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (sys_rst_i);

    a_half_in_prog: assert property (req_r.req && req_r.we && req_r.addr == word_addr_r && !mode_r[1]
        |-> req_r.size == fepc_pkg::SIZE_HALF) else $error("flash write not half-word in prog mode");
    a_no_rom_write: assert property (req_r.req && req_r.we && req_r.addr[31:16] != fepc_pkg::DEV_STATUS[31:16]
        && state_r != ST_HANG_CMD |-> mode_r == fepc_pkg::ASZ_PROG) else $error("flash written in read mode");
    a_dummy_after_cmd: assert property (ack && (state_r == ST_LO_WR || state_r == ST_HI_WR)
        |=> req_r.req && !req_r.we ##1 req_r.req && !req_r.we) else $error("no dummy read after command");
    a_poll_after_dummy: assert property (ack && state_r == ST_LO_DUMMY
        |=> state_r == ST_LO_POLL && req_r.req) else $error("flags not polled after dummy");
    a_upper_after_lower: assert property (req_r.req && state_r == ST_HI_WR
        |-> lo_ok_r && req_r.addr == word_addr_r + 32'h2) else $error("upper half before lower");
    a_asz_dummy: assert property (ack && (state_r == ST_ASZ_P_WR || state_r == ST_ASZ_R_WR)
        |=> !req_r.we && req_r.addr == fepc_pkg::DEV_ACCESS_SIZE) else $error("no dummy read of size reg");
    a_hang_reset: assert property (ack && (state_r == ST_LO_STS || state_r == ST_HI_STS) && rd[1]
        |=> req_r.we && req_r.wdata == fepc_pkg::RESET_CMD) else $error("hang not followed by reset");
    a_ecc_report: assert property (ack && state_r == ST_EER_RD
        |=> stat_r[fepc_pkg::STAT_ECC] == $past(rd[2]) && !busy_o) else $error("ecc flag lost");
    a_prog_busy: assert property (prog_mode_o |-> busy_o) else $error("prog mode left set while idle");
    a_slow_legal: assert property (req_r.req && req_r.we && req_r.addr == fepc_pkg::DEV_SLOW_DOWN
        |-> slow_legal(req_r.wdata[2:0])) else $error("prohibited slow-down code");
endmodule

// File: logic/fepc_pkg.sv
// Purpose: constants and carrier types for the flash ECC program controller
// Assumes: device registers sit at fixed addresses in the device's bus space
// Notes: all addresses and command codes are shared by the controller and the bench flash model
package fepc_pkg;
    // own register map, byte addresses on the software port
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_ADDR = 8'h04;
    localparam logic [7:0] REG_DATA = 8'h08;
    localparam logic [7:0] REG_STAT = 8'h0c;
    localparam logic [7:0] REG_TRIM = 8'h10;
    localparam logic [7:0] REG_SLOW = 8'h14;
    // control bits (write 1 to start)
    localparam int CTRL_PROG = 0;
    localparam int CTRL_TRIM = 1;
    localparam int CTRL_CLR_EER = 2;
    localparam int CTRL_SLOW = 3;
    // own status bits
    localparam int STAT_BUSY = 0;
    localparam int STAT_DONE = 1;
    localparam int STAT_HANG = 2;
    localparam int STAT_ECC = 3;
    localparam int STAT_VERIFY = 4;
    localparam int STAT_SLOW_BAD = 5;
    // device register addresses
    localparam logic [31:0] DEV_ACCESS_SIZE = 32'h4000_0000;
    localparam logic [31:0] DEV_READ_WAIT = 32'h4000_0004;
    localparam logic [31:0] DEV_STATUS = 32'h4000_0008;
    localparam logic [31:0] DEV_SLOW_DOWN = 32'h4000_000c;
    localparam logic [31:0] DEV_TRIM_MIRROR = 32'h4000_0100;
    // access size codes, also used as bus size codes
    localparam logic [1:0] ASZ_PROG = 2'h1;
    localparam logic [1:0] ASZ_ROM = 2'h2;
    localparam logic [1:0] ASZ_RESET = 2'h2;
    localparam logic [1:0] SIZE_HALF = 2'h1;
    localparam logic [1:0] SIZE_WORD = 2'h2;
    // device flag positions
    localparam int FLAG_DONE_POLARITY = 7;
    localparam int DSTAT_READY = 0;
    localparam int DSTAT_HANG = 1;
    localparam int DSTAT_EER = 2;
    localparam int TRIM_W = 10;
    localparam logic [31:0] RESET_CMD = 32'h0000_00f0;
    localparam logic [31:0] WORD_HI_OFS = 32'h0000_0002;
    localparam logic [31:0] EER_CLEAR_WORD = 32'h0000_0003;

    typedef struct packed {
        logic req;
        logic we;
        logic [1:0] size;
        logic [31:0] addr;
        logic [31:0] wdata;
    } fepc_dev_req_type;

    typedef struct packed {
        logic ack;
        logic [31:0] rdata;
    } fepc_dev_rsp_type;
endpackage

// File: testbench/fepc_flash_model.sv
// Purpose: behavioural flash device seen by the controller's device port
// Assumes: one request at a time, fields held until ack
// Notes: first flash read after a command looks finished on purpose, to catch a missing discard
`timescale 1ns/1ns
module fepc_flash_model #(
    parameter logic [31:0] TRIM_WORD = 32'h0000_0ebc,
    parameter int BUSY_POLLS = 3
) (
    input wire logic sys_clk_i,
    input wire logic sys_rst_i,
    input wire fepc_pkg::fepc_dev_req_type dev_req_i,
    output fepc_pkg::fepc_dev_rsp_type dev_rsp_o,
    input wire logic [3:0] lat_i,
    input wire logic ecc_i,
    input wire logic hang_i
);
    logic [31:0] mem [0:255];
    logic [1:0] asz_r;
    logic [1:0] rwt_r;
    logic [2:0] sd_r;
    logic eer_r;
    logic got_rst_r;
    logic fresh_r;
    logic [15:0] lo_r;
    logic [31:0] lo_addr_r;
    logic [7:0] proto_err;
    int busy_left;
    int wcnt;
    logic [31:0] a;
    logic [31:0] wd;

    always @(posedge sys_clk_i) begin
        a = dev_req_i.addr;
        wd = dev_req_i.wdata;
        dev_rsp_o.ack <= 1'b0;
        dev_rsp_o.rdata <= ~dev_rsp_o.rdata;
        if (sys_rst_i) begin
            asz_r <= fepc_pkg::ASZ_RESET;
            rwt_r <= 2'h0;
            sd_r <= 3'h0;
            eer_r <= 1'b0;
            got_rst_r <= 1'b0;
            fresh_r <= 1'b0;
            proto_err <= 8'h00;
            busy_left <= 0;
            wcnt <= 0;
            dev_rsp_o.rdata <= 32'h0;
        end else if (dev_req_i.req && !dev_rsp_o.ack) begin
            if (wcnt < int'(lat_i)) begin
                wcnt <= wcnt + 1;
            end else begin
                wcnt <= 0;
                dev_rsp_o.ack <= 1'b1;
                if (dev_req_i.we) begin
                    case (a)
                        fepc_pkg::DEV_ACCESS_SIZE: asz_r <= wd[1:0];
                        fepc_pkg::DEV_READ_WAIT: rwt_r <= {wd[1], 1'b0};
                        fepc_pkg::DEV_STATUS: if (!wd[2]) eer_r <= 1'b0;
                        fepc_pkg::DEV_SLOW_DOWN: sd_r <= wd[2:0];
                        fepc_pkg::DEV_TRIM_MIRROR: proto_err <= proto_err + 8'h01;
                        default: begin
                            fresh_r <= 1'b1;
                            if (wd == fepc_pkg::RESET_CMD) begin
                                got_rst_r <= 1'b1;
                                busy_left <= 0;
                            end else if (asz_r != fepc_pkg::ASZ_PROG || dev_req_i.size != fepc_pkg::SIZE_HALF) begin
                                proto_err <= proto_err + 8'h01;
                            end else if (busy_left != 0) begin
                                proto_err <= proto_err + 8'h01;
                            end else if (!a[1]) begin
                                lo_r <= wd[15:0];
                                lo_addr_r <= a;
                                busy_left <= BUSY_POLLS;
                            end else if (a == lo_addr_r + fepc_pkg::WORD_HI_OFS) begin
                                mem[lo_addr_r[9:2]] <= {wd[15:0], lo_r};
                                busy_left <= BUSY_POLLS;
                            end else begin
                                proto_err <= proto_err + 8'h01;
                            end
                        end
                    endcase
                end else begin
                    case (a)
                        fepc_pkg::DEV_ACCESS_SIZE: dev_rsp_o.rdata <= {30'h0, asz_r};
                        fepc_pkg::DEV_READ_WAIT: dev_rsp_o.rdata <= {30'h0, rwt_r};
                        // bits 7:3 carry a junk pattern since they read undefined
                        fepc_pkg::DEV_STATUS: dev_rsp_o.rdata <= {24'h0, 5'h15, eer_r, hang_i && busy_left != 0,
                            busy_left == 0};
                        fepc_pkg::DEV_SLOW_DOWN: dev_rsp_o.rdata <= {29'h0, sd_r};
                        fepc_pkg::DEV_TRIM_MIRROR: dev_rsp_o.rdata <= {22'h0, TRIM_WORD[9:0]};
                        default: begin
                            fresh_r <= 1'b0;
                            if (fresh_r) begin
                                dev_rsp_o.rdata <= 32'h0000_0080;
                            end else if (busy_left != 0) begin
                                dev_rsp_o.rdata <= {24'h0, 2'b00, hang_i, 5'h00};
                                if (!hang_i) busy_left <= busy_left - 1;
                            end else if (asz_r == fepc_pkg::ASZ_PROG) begin
                                dev_rsp_o.rdata <= 32'h0000_0080;
                            end else begin
                                dev_rsp_o.rdata <= mem[a[9:2]];
                                if (ecc_i) eer_r <= 1'b1;
                            end
                        end
                    endcase
                end
            end
        end
    end
endmodule

// File: testbench/test_fepc_ctrl.sv
// Purpose: self-checking bench for the flash ECC program controller
// Assumes: device model answers with selectable latency
// Notes: poll limit shortened to 8; the hang test enters the hang path on the model's hang flag, not the limit
`timescale 1ns/1ns
module test_fepc_ctrl;
    localparam logic [31:0] TRIM_WORD = 32'h0000_0ebc;
    logic sys_clk_i = 1'b0;
    logic sys_rst_i = 1'b1;
    logic [7:0] sw_addr = 8'h00;
    logic [31:0] sw_wdata = 32'h0;
    logic sw_wr = 1'b0;
    logic sw_rd = 1'b0;
    logic [31:0] sw_rdata;
    fepc_pkg::fepc_dev_req_type dev_req;
    fepc_pkg::fepc_dev_rsp_type dev_rsp;
    logic prog_mode;
    logic busy;
    logic [3:0] lat = 4'h0;
    logic ecc = 1'b0;
    logic hang = 1'b0;
    int err_count = 0;
    int checks_done = 0;
    logic [31:0] d;

    fepc_ctrl #(.POLL_LIMIT(8)) dut (.sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i), .sw_addr_i(sw_addr),
        .sw_wdata_i(sw_wdata), .sw_wr_i(sw_wr), .sw_rd_i(sw_rd), .sw_rdata_o(sw_rdata), .dev_req_o(dev_req),
        .dev_rsp_i(dev_rsp), .prog_mode_o(prog_mode), .busy_o(busy));
    fepc_flash_model #(.TRIM_WORD(TRIM_WORD)) partner (.sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i),
        .dev_req_i(dev_req), .dev_rsp_o(dev_rsp), .lat_i(lat), .ecc_i(ecc), .hang_i(hang));

    initial begin
        forever #2 sys_clk_i = ~sys_clk_i;
    end

    task automatic summarize();
        $display("errors %0d checks %0d", err_count, checks_done);
        if (err_count == 0 && checks_done > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            err_count++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic sw_write(input logic [7:0] a, input logic [31:0] v);
        @(posedge sys_clk_i);
        sw_addr <= a;
        sw_wdata <= v;
        sw_wr <= 1'b1;
        @(posedge sys_clk_i);
        sw_wr <= 1'b0;
    endtask

    task automatic sw_read(input logic [7:0] a, output logic [31:0] v);
        @(posedge sys_clk_i);
        sw_addr <= a;
        sw_rd <= 1'b1;
        @(posedge sys_clk_i);
        sw_rd <= 1'b0;
        #1 v = sw_rdata;
    endtask

    // bounded wait so a stuck sequence shows up as a mismatch, not a hang
    task automatic run(input logic [7:0] ctrl);
        sw_write(fepc_pkg::REG_CTRL, {24'h0, ctrl});
        #1;
        for (int n = 0; n < 5000 && busy !== 1'b0; n++) begin
            @(posedge sys_clk_i);
            #1;
        end
        check({31'h0, busy}, 32'h0);
    endtask

    task automatic t_prog(input logic [31:0] a, input logic [31:0] v, input logic [3:0] l, input logic [31:0] st);
        lat <= l;
        sw_write(fepc_pkg::REG_ADDR, a);
        sw_write(fepc_pkg::REG_DATA, v);
        run(8'h01);
        sw_read(fepc_pkg::REG_STAT, d);
        check(d, st);
        check({30'h0, partner.asz_r}, {30'h0, fepc_pkg::ASZ_ROM});
        check({31'h0, prog_mode}, 32'h0);
    endtask

    task automatic t_slow();
        logic [2:0] legal [5] = '{3'h0, 3'h1, 3'h3, 3'h5, 3'h7};
        foreach (legal[i]) begin
            sw_write(fepc_pkg::REG_SLOW, {29'h0, legal[i]});
            run(8'h08);
            check({29'h0, partner.sd_r}, {29'h0, legal[i]});
        end
        for (int c = 2; c < 8; c += 2) begin
            sw_write(fepc_pkg::REG_SLOW, 32'(c));
            run(8'h08);
            sw_read(fepc_pkg::REG_STAT, d);
            check({31'h0, d[fepc_pkg::STAT_SLOW_BAD]}, 32'h1);
            check({29'h0, partner.sd_r}, 32'h7);
        end
    endtask

    initial begin
        #100000;
        err_count++;
        summarize();
    end

    initial begin
        repeat (12) @(posedge sys_clk_i);
        sys_rst_i <= 1'b0;
        check({30'h0, partner.asz_r}, {30'h0, fepc_pkg::ASZ_RESET});
        check({30'h0, partner.rwt_r}, 32'h0);
        sw_read(8'h20, d);
        check(d, 32'h0);
        run(8'h02);
        sw_read(fepc_pkg::REG_TRIM, d);
        check(d, {22'h0, TRIM_WORD[9:0]});
        t_prog(32'h100, 32'hcafe_1234, 4'h0, 32'h2);
        t_prog(32'h104, 32'h8001_7ffe, 4'h3, 32'h2);
        check(partner.mem[8'h40], 32'hcafe_1234);
        check(partner.mem[8'h41], 32'h8001_7ffe);
        ecc <= 1'b1;
        t_prog(32'h108, 32'h5a5a_a5a5, 4'h1, 32'ha);
        check({31'h0, partner.eer_r}, 32'h1);
        ecc <= 1'b0;
        run(8'h04);
        check({31'h0, partner.eer_r}, 32'h0);
        hang <= 1'b1;
        lat <= 4'h0;
        sw_write(fepc_pkg::REG_ADDR, 32'h10c);
        run(8'h01);
        sw_read(fepc_pkg::REG_STAT, d);
        check({31'h0, d[fepc_pkg::STAT_HANG]}, 32'h1);
        check({31'h0, partner.got_rst_r}, 32'h1);
        check({30'h0, partner.asz_r}, {30'h0, fepc_pkg::ASZ_ROM});
        hang <= 1'b0;
        t_slow();
        check({24'h0, partner.proto_err}, 32'h0);
        summarize();
    end
endmodule
